// [hw/wpd_cfg.svh]
// address map, field positions, reset values and timing figures of the presence detector
`ifndef WPD_CFG_SVH
`define WPD_CFG_SVH
`define WPD_A_OPC 8'h02
`define WPD_A_ADC 8'h25
`define WPD_A_CAPCTL 8'h2E
`define WPD_A_CAPDISP 8'h2F
`define WPD_A_WUT 8'h31
`define WPD_A_MBASE 8'h32
`define WPD_A_MLAST 8'h3D
`define WPD_A_CAUSE 8'h3E
`define WPD_A_CMD 8'h3F
`define WPD_OPC_WU 8'h04
`define WPD_OPC_RST 8'h00
`define WPD_WUT_RST 8'h40
`define WPD_CONF_RST 8'h00
`define WPD_CMD_MEAS_CAP 8'h01
`define WPD_CMD_CALIB 8'h02
`define WPD_CMD_SET_DEF 8'h03
`define WPD_WUT_PER_HI 6
`define WPD_WUT_PER_LO 4
`define WPD_WUT_CAP 2
`define WPD_WUT_PHS 1
`define WPD_WUT_AMP 0
`define WPD_CONF_THR_HI 7
`define WPD_CONF_THR_LO 4
`define WPD_CONF_AAM 3
`define WPD_CONF_WGT_HI 2
`define WPD_CONF_WGT_LO 1
`define WPD_CONF_AUTO 0
`define WPD_CAL_HI 7
`define WPD_CAL_LO 3
`define WPD_CAL_DONE 1
`define WPD_CAL_BUSY 0
`define WPD_CAL_W 5
`define WPD_CAL_FIRST 5'h10
`define WPD_CAL_TARGET 8'h80
`define WPD_PER0_MS 10
`define WPD_PER1_MS 20
`define WPD_PER2_MS 30
`define WPD_PER3_MS 50
`define WPD_PER4_MS 100
`define WPD_PER5_MS 200
`define WPD_PER6_MS 400
`define WPD_PER7_MS 800
`define WPD_CLK_HZ 50000000
`define WPD_CLK_NS 20
`define WPD_RC_HZ 32000
`define WPD_CAP_MEAS_NS 200000
`define WPD_FIELD_NS 20000
`endif

// [hw/wpd_pkg.sv]
// types shared by the presence detector
package wpd_pkg;
	typedef enum logic [1:0] {WPD_IDLE, WPD_WAIT, WPD_MEAS, WPD_EVAL} wpd_state_t;
	typedef enum logic [1:0] {WPD_P_WAKE, WPD_P_CMD, WPD_P_CAL} wpd_purp_t;
	typedef logic [1:0] wpd_meth_t;
	localparam wpd_meth_t WPD_M_AMP = 2'h0;
	localparam wpd_meth_t WPD_M_PHS = 2'h1;
	localparam wpd_meth_t WPD_M_CAP = 2'h2;
	localparam wpd_meth_t WPD_M_NONE = 2'h3;
endpackage

// [hw/wpd_top.sv]
// wake-up presence detector: scheduler, capacitive sensing, averaging and compare
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "wpd_cfg.svh"

// Summary of operation
// - capacitance command measures once, result to converter
// - capacitive measurement lasts 200 microseconds
// - five-bit compensation code, 0.1 pF steps
// - host writes code or device searches it
// - wake mode when only wake bit set
// - period timer runs from 32 kHz tick
// - repeat measurements, interrupt only on change
// - field enabled about 20 microseconds per phase or amplitude measurement
// - wake registers at 31h through 3Dh
// - period 10 to 800 ms, default 100
// - any subset of three methods selectable
// - four registers per method
// - interrupt when difference exceeds threshold
// - reference is average or host value
// - config holds threshold, source and weight
// - average moves by difference over weight
// - averaging carried with ten bits
// - averaging initialised on first entry after default
// - start average from result while result zero
// - config bit folds triggering result into average
module wpd_top import wpd_pkg::*; #(
	parameter int CAP_MEAS_NS = `WPD_CAP_MEAS_NS,
	parameter int RC_DIV = `WPD_CLK_HZ / `WPD_RC_HZ
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// host wake interrupt
	output logic WAKE_IRQ,
	// analog front end
	input wire logic [7:0] ADC_DATA,
	output logic FIELD_EN,
	output logic EXCITATION_ELECTRODE_EN,
	output logic [1:0] MEAS_SEL,
	output logic [4:0] CAL_CODE
);
	// long measurement counted at clock rate, parameter so a bench may shorten it
	localparam int CAP_CYC = (CAP_MEAS_NS + `WPD_CLK_NS - 1) / `WPD_CLK_NS;
	localparam int FIELD_CYC = (`WPD_FIELD_NS + `WPD_CLK_NS - 1) / `WPD_CLK_NS;
	// one counter serves both windows, so it is sized for the longer one
	localparam int MAX_CYC = (CAP_CYC > FIELD_CYC) ? CAP_CYC : FIELD_CYC;
	localparam int CNT_W = $clog2(MAX_CYC + 1);
	localparam int DIV_W = $clog2(RC_DIV + 1);
	localparam int TICK_MS = `WPD_RC_HZ / 1000;

	generate
		if (CAP_CYC < 1 || RC_DIV < 2) begin : g_bad
			$error("wpd_top: measurement or divider setting too small");
		end
	endgenerate

	// control registers
	logic [7:0] op_ctrl;
	logic [7:0] wut;
	logic [7:0] capctl;
	logic [7:0] conf [3];
	logic [7:0] href [3];
	// state shown to software, and the averaging start flag
	logic [9:0] avg [3];
	logic [7:0] res [3];
	logic [7:0] adc_out;
	logic [2:0] cause;
	logic [4:0] cal_code;
	logic cal_busy;
	logic cal_done;
	logic avg_init;
	// sequencer
	wpd_state_t state;
	wpd_meth_t meth;
	wpd_purp_t purp;
	logic [14:0] tmr;
	logic [DIV_W-1:0] rc_div;
	logic [CNT_W-1:0] cnt;
	logic [2:0] cal_bit;
	logic [7:0] adc_m;
	logic [7:0] adc_s;

	// converter input pins cross into the clock domain first; the register port is used as it arrives
	always_ff @(posedge SYS_CLK) begin
		adc_m <= ADC_DATA;
		adc_s <= adc_m;
	end

	// decode
	wire wr_cmd = WR && ADDR == `WPD_A_CMD;
	wire set_def = wr_cmd && WDATA == `WPD_CMD_SET_DEF;
	// every other bit must be zero
	wire wake_mode = op_ctrl == `WPD_OPC_WU;
	wire in_mblk = ADDR >= `WPD_A_MBASE && ADDR <= `WPD_A_MLAST;
	wire [7:0] moff = ADDR - `WPD_A_MBASE;
	// method index and register within the group of four
	wire [1:0] msel = moff[3:2];
	wire [1:0] mreg = moff[1:0];
	wire rc_tick = rc_div == '0;
	wire [2:0] en_bits = {wut[`WPD_WUT_CAP], wut[`WPD_WUT_PHS], wut[`WPD_WUT_AMP]};

	// first enabled method at or after a start index
	function automatic wpd_meth_t next_meth(input logic [2:0] en, input logic [2:0] from);
		wpd_meth_t r;
		r = WPD_M_NONE;
		for (int i = 2; i >= 0; i--) begin
			if (en[i] && 3'(i) >= from) begin
				r = wpd_meth_t'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [14:0] per_ticks(input logic [2:0] code);
		int ms;
		ms = `WPD_PER4_MS;
		unique case (code)
			3'h0: ms = `WPD_PER0_MS;
			3'h1: ms = `WPD_PER1_MS;
			3'h2: ms = `WPD_PER2_MS;
			3'h3: ms = `WPD_PER3_MS;
			3'h4: ms = `WPD_PER4_MS;
			3'h5: ms = `WPD_PER5_MS;
			3'h6: ms = `WPD_PER6_MS;
			3'h7: ms = `WPD_PER7_MS;
		endcase
		return 15'(ms * TICK_MS);
	endfunction

	wire [14:0] period = per_ticks(wut[`WPD_WUT_PER_HI:`WPD_WUT_PER_LO]);
	wire wpd_meth_t first_m = next_meth(en_bits, 3'h0);
	wire wpd_meth_t after_m = next_meth(en_bits, 3'({1'b0, meth}) + 3'h1);

	// evaluation of the measurement just finished
	wire [1:0] mi = (meth == WPD_M_NONE) ? 2'h0 : meth;
	wire [7:0] cf = conf[mi];
	wire [7:0] refv = cf[`WPD_CONF_AUTO] ? avg[mi][9:2] : href[mi];
	wire [7:0] diff = (adc_s > refv) ? adc_s - refv : refv - adc_s;
	wire hit = diff > {4'h0, cf[`WPD_CONF_THR_HI:`WPD_CONF_THR_LO]};
	// ten-bit step, weight a power of two
	wire [1:0] wsh = cf[`WPD_CONF_WGT_HI:`WPD_CONF_WGT_LO];
	wire signed [11:0] delta = signed'({2'b00, adc_s, 2'b00} - {2'b00, avg[mi]});
	wire signed [11:0] step = delta >>> wsh;
	wire [11:0] sum = {2'b00, avg[mi]} + step;
	// seed from result while the result display is still zero
	wire [9:0] new_avg = (res[mi] == 8'h00) ? {adc_s, 2'b00} : sum[9:0];
	// triggering result only folded in when allowed
	wire do_avg = cf[`WPD_CONF_AUTO] && (!hit || cf[`WPD_CONF_AAM]);

	// software-written registers
	always_ff @(posedge SYS_CLK) begin
		if (RST || set_def) begin
			op_ctrl <= `WPD_OPC_RST;
			wut <= `WPD_WUT_RST;
			capctl <= 8'h00;
			for (int i = 0; i < 3; i++) begin
				conf[i] <= `WPD_CONF_RST;
				href[i] <= 8'h00;
			end
		end else if (WR) begin
			if (ADDR == `WPD_A_OPC) op_ctrl <= WDATA;
			if (ADDR == `WPD_A_CAPCTL) capctl <= WDATA;
			if (ADDR == `WPD_A_WUT) wut <= WDATA;
			// config and host reference per method
			if (in_mblk && mreg == 2'h0) conf[msel] <= WDATA;
			if (in_mblk && mreg == 2'h1) href[msel] <= WDATA;
		end
	end

	// slow tick standing in for the RC oscillator
	always_ff @(posedge SYS_CLK) begin
		if (RST || rc_tick) rc_div <= DIV_W'(RC_DIV - 1);
		else rc_div <= rc_div - 1'b1;
	end

	// read path, data valid in the cycle after the strobe
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (ADDR == `WPD_A_OPC) rd_mux = op_ctrl;
		if (ADDR == `WPD_A_ADC) rd_mux = adc_out;
		if (ADDR == `WPD_A_CAPCTL) rd_mux = capctl;
		if (ADDR == `WPD_A_CAPDISP) rd_mux = {cal_code, 1'b0, cal_done, cal_busy};
		if (ADDR == `WPD_A_WUT) rd_mux = wut;
		if (ADDR == `WPD_A_CAUSE) rd_mux = {5'h00, cause};
		if (in_mblk) begin
			unique case (mreg)
				2'h0: rd_mux = conf[msel];
				2'h1: rd_mux = href[msel];
				2'h2: rd_mux = avg[msel][9:2];
				2'h3: rd_mux = res[msel];
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) RDATA <= 8'h00;
		else if (RD) RDATA <= rd_mux;
		else RDATA <= 8'h00;
	end

	// sequencer
	wire eval_wake = state == WPD_EVAL && purp == WPD_P_WAKE;
	wire irq_set = eval_wake && hit;
	always_ff @(posedge SYS_CLK) begin
		if (RST || set_def) begin
			state <= WPD_IDLE;
			meth <= WPD_M_NONE;
			purp <= WPD_P_WAKE;
			tmr <= '0;
			cnt <= '0;
			cal_bit <= 3'h0;
			cal_code <= '0;
			cal_busy <= 1'b0;
			cal_done <= 1'b0;
			adc_out <= 8'h00;
			// averaging restarts after power-up or default
			avg_init <= 1'b1;
			for (int i = 0; i < 3; i++) begin
				avg[i] <= '0;
				res[i] <= 8'h00;
			end
		end else begin
			unique case (state)
				WPD_IDLE: begin
					if (wake_mode) begin
						purp <= WPD_P_WAKE;
						tmr <= period;
						state <= WPD_WAIT;
						// first entry clears the result displays
						if (avg_init) begin
							avg_init <= 1'b0;
							for (int i = 0; i < 3; i++) res[i] <= 8'h00;
						end
					end else if (wr_cmd && WDATA == `WPD_CMD_MEAS_CAP) begin
						purp <= WPD_P_CMD;
						meth <= WPD_M_CAP;
						cnt <= CNT_W'(CAP_CYC - 1);
						state <= WPD_MEAS;
					end else if (wr_cmd && WDATA == `WPD_CMD_CALIB) begin
						// search from the top bit down
						purp <= WPD_P_CAL;
						meth <= WPD_M_CAP;
						cal_busy <= 1'b1;
						cal_done <= 1'b0;
						cal_code <= `WPD_CAL_FIRST;
						cal_bit <= 3'(`WPD_CAL_W - 1);
						cnt <= CNT_W'(CAP_CYC - 1);
						state <= WPD_MEAS;
					end
				end
				WPD_WAIT: begin
					if (!wake_mode) begin
						state <= WPD_IDLE;
					end else if (tmr == '0) begin
						// expiry starts the enabled methods in turn
						if (first_m == WPD_M_NONE) begin
							tmr <= period;
						end else begin
							meth <= first_m;
							cnt <= (first_m == WPD_M_CAP) ? CNT_W'(CAP_CYC - 1)
								: CNT_W'(FIELD_CYC - 1);
							state <= WPD_MEAS;
						end
					end else if (rc_tick) begin
						tmr <= tmr - 1'b1;
					end
				end
				WPD_MEAS: begin
					if (cnt == '0) state <= WPD_EVAL;
					else cnt <= cnt - 1'b1;
				end
				WPD_EVAL: begin
					unique case (purp)
						WPD_P_CMD: begin
							adc_out <= adc_s;
							state <= WPD_IDLE;
						end
						WPD_P_CAL: begin
							// keep the bit while the reading stays high
							adc_out <= adc_s;
							if (adc_s < `WPD_CAL_TARGET) cal_code[cal_bit] <= 1'b0;
							if (cal_bit == 3'h0) begin
								cal_busy <= 1'b0;
								cal_done <= 1'b1;
								state <= WPD_IDLE;
							end else begin
								cal_code[cal_bit - 3'h1] <= 1'b1;
								cal_bit <= cal_bit - 3'h1;
								cnt <= CNT_W'(CAP_CYC - 1);
								state <= WPD_MEAS;
							end
						end
						WPD_P_WAKE: begin
							res[mi] <= adc_s;
							if (do_avg) avg[mi] <= new_avg;
							// next method or back to the period wait
							if (after_m == WPD_M_NONE) begin
								tmr <= period;
								state <= WPD_WAIT;
							end else begin
								meth <= after_m;
								cnt <= (after_m == WPD_M_CAP) ? CNT_W'(CAP_CYC - 1)
									: CNT_W'(FIELD_CYC - 1);
								state <= WPD_MEAS;
							end
						end
						default: state <= WPD_IDLE;
					endcase
				end
			endcase
		end
	end

	// cause bits: set beats clear on read
	wire cause_rd = RD && ADDR == `WPD_A_CAUSE;
	always_ff @(posedge SYS_CLK) begin
		if (RST) cause <= 3'h0;
		else if (irq_set) cause <= (cause_rd ? 3'h0 : cause) | (3'h1 << mi);
		else if (cause_rd) cause <= 3'h0;
	end

	// outputs straight from flops
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			WAKE_IRQ <= 1'b0;
			FIELD_EN <= 1'b0;
			EXCITATION_ELECTRODE_EN <= 1'b0;
			MEAS_SEL <= 2'h0;
			CAL_CODE <= 5'h00;
		end else begin
			WAKE_IRQ <= irq_set;
			// field only during phase or amplitude windows
			FIELD_EN <= state == WPD_MEAS && meth != WPD_M_CAP;
			EXCITATION_ELECTRODE_EN <= state == WPD_MEAS && meth == WPD_M_CAP;
			MEAS_SEL <= mi;
			CAL_CODE <= cal_busy ? cal_code : capctl[`WPD_CAL_HI:`WPD_CAL_LO];
		end
	end

	// helper counters for checks
	logic [CNT_W:0] exc_len;
	logic [CNT_W:0] fld_len;
	always_ff @(posedge SYS_CLK) begin
		exc_len <= EXCITATION_ELECTRODE_EN ? exc_len + 1'b1 : '0;
		fld_len <= FIELD_EN ? fld_len + 1'b1 : '0;
	end

	sequence s_eval_wake;
		state == WPD_EVAL && purp == WPD_P_WAKE;
	endsequence
	sequence s_last_method;
		after_m == WPD_M_NONE;
	endsequence

	a_cap_duration: assert property (@(posedge SYS_CLK) disable iff (RST)
		$fell(EXCITATION_ELECTRODE_EN) |-> exc_len == (CNT_W+1)'(CAP_CYC))
		else $error("capacitive window length wrong");
	a_field_duration: assert property (@(posedge SYS_CLK) disable iff (RST)
		$fell(FIELD_EN) |-> fld_len == (CNT_W+1)'(FIELD_CYC))
		else $error("field window length wrong");
	a_cmd_result: assert property (@(posedge SYS_CLK) disable iff (RST)
		state == WPD_EVAL && purp == WPD_P_CMD |=> adc_out == $past(adc_s) && state == WPD_IDLE)
		else $error("capacitance result not stored");
	a_wake_entry: assert property (@(posedge SYS_CLK) disable iff (RST)
		state == WPD_IDLE && op_ctrl == `WPD_OPC_WU && !set_def |=> state == WPD_WAIT)
		else $error("wake mode not entered");
	a_irq_cause: assert property (@(posedge SYS_CLK) disable iff (RST)
		s_eval_wake ##0 (diff > {4'h0, cf[`WPD_CONF_THR_HI:`WPD_CONF_THR_LO]}) |=> WAKE_IRQ)
		else $error("missed wake interrupt");
	a_irq_quiet: assert property (@(posedge SYS_CLK) disable iff (RST)
		WAKE_IRQ |-> $past(state) == WPD_EVAL && $past(purp) == WPD_P_WAKE)
		else $error("spurious wake interrupt");
	a_avg_hold: assert property (@(posedge SYS_CLK) disable iff (RST || set_def)
		s_eval_wake ##0 (hit && !cf[`WPD_CONF_AAM]) |=> avg[$past(mi)] == $past(avg[mi]))
		else $error("triggering result folded into average");
	a_timer_reload: assert property (@(posedge SYS_CLK) disable iff (RST || set_def)
		s_eval_wake ##0 s_last_method |=> state == WPD_WAIT && tmr == period)
		else $error("period not restarted");
	a_cal_steps: assert property (@(posedge SYS_CLK) disable iff (RST || set_def)
		state == WPD_EVAL && purp == WPD_P_CAL && cal_bit == 3'h0 |=> cal_done && !cal_busy)
		else $error("calibration status not reported");
	a_one_field: assert property (@(posedge SYS_CLK) disable iff (RST)
		!(FIELD_EN && EXCITATION_ELECTRODE_EN))
		else $error("field and excitation both on");
endmodule

// [testbench/wpd_afe_model.sv]
// analog front end stand-in: converter readings per active method
`timescale 1ns/1ps
module wpd_afe_model (
	// clock and front-end controls
	input wire logic clk,
	input wire logic field_en,
	input wire logic exc_en,
	input wire logic [1:0] meas_sel,
	input wire logic [4:0] cal_code,
	// scene set by the bench
	input wire logic [7:0] amp_val,
	input wire logic [7:0] phs_val,
	input wire logic [7:0] parasitic,
	// converter output
	output logic [7:0] adc_data
);
	logic [7:0] idle_pat = 8'h5A;
	logic [8:0] comp;
	// each code step removes four counts
	assign comp = {1'b0, parasitic} - {2'h0, cal_code, 2'h0};
	// idle output keeps moving so a stale sample shows
	always @(posedge clk) begin
		idle_pat <= ~idle_pat + 8'h01;
	end
	assign adc_data = exc_en ? (comp[8] ? 8'h00 : comp[7:0]) :
		field_en ? (meas_sel == 2'h1 ? phs_val : amp_val) : idle_pat;
endmodule

// [testbench/wakeup_presence_detector_tb.sv]
// self-checking bench of the presence detector
`timescale 1ns/1ps
`include "wpd_cfg.svh"
module wakeup_presence_detector_tb;
	localparam int DIV = 4;
	localparam int CAP_CYC = 10;
	localparam int PER_CYC = `WPD_PER0_MS * 32 * DIV;
	localparam int FIELD_CYC = `WPD_FIELD_NS / `WPD_CLK_NS;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [7:0] rdata;
	logic wake_irq;
	logic [7:0] adc;
	logic field_en;
	logic exc_en;
	logic [1:0] meas_sel;
	logic [4:0] cal_code;
	logic [7:0] amp_val = 8'h00;
	logic [7:0] phs_val = 8'h00;
	logic [7:0] parasitic = 8'h00;
	logic [7:0] v, ref_v, c1, c2;
	logic [3:0] thr;
	logic [1:0] wgt;
	logic [4:0] code;
	int seed = 81672;
	int error_cnt = 0;
	int n_compared = 0;
	int irq_cnt = 0;
	int n;

	wpd_top #(.CAP_MEAS_NS(200), .RC_DIV(DIV)) dut_u (
		.SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
		.RDATA(rdata), .WAKE_IRQ(wake_irq), .ADC_DATA(adc), .FIELD_EN(field_en),
		.EXCITATION_ELECTRODE_EN(exc_en), .MEAS_SEL(meas_sel), .CAL_CODE(cal_code)
	);
	wpd_afe_model afe_u (
		.clk(clk), .field_en(field_en), .exc_en(exc_en), .meas_sel(meas_sel),
		.cal_code(cal_code), .amp_val(amp_val), .phs_val(phs_val),
		.parasitic(parasitic), .adc_data(adc)
	);

	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (wake_irq === 1'b1) irq_cnt++;
	end

	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		q = rdata;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		rd(a, q);
		chk(q, exp);
	endtask
	function automatic logic pick(input int which);
		return which == 0 ? field_en : which == 1 ? exc_en : wake_irq;
	endfunction
	// bounded wait on a level; n counts cycles, -1 when it never came
	task automatic wait_for(input int which, input logic lvl, input int max, input bit must,
		output int cnt);
		cnt = 0;
		@(negedge clk);
		while (cnt < max && pick(which) !== lvl) begin
			@(negedge clk);
			cnt++;
		end
		if (pick(which) !== lvl) begin
			cnt = -1;
			if (must) begin
				error_cnt++;
				$display("unexpected at %0t: wait %0h level %0h", $time, which, lvl);
				results();
			end
		end
	endtask
	function automatic logic [7:0] exp_avg(input logic [7:0] a, input logic [7:0] b,
		input logic [1:0] w);
		int s;
		s = a * 4;
		s = s + ((b * 4 - s) >>> w);
		return 8'((s >> 2) & 255);
	endfunction

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdchk(`WPD_A_WUT, `WPD_WUT_RST);
		rdchk(`WPD_A_MBASE, `WPD_CONF_RST);
		rdchk(`WPD_A_OPC, `WPD_OPC_RST);
		rdchk(8'h50, 8'h00);
		rdchk(`WPD_A_CAUSE, 8'h00);
		// single capacitive measurement on command
		parasitic = 8'($random(seed));
		wr(`WPD_A_CMD, `WPD_CMD_MEAS_CAP);
		wait_for(1, 1'b1, 8, 1, n);
		chk(meas_sel, 2'h2);
		wait_for(1, 1'b0, CAP_CYC + 8, 1, n);
		// first high cycle was already taken by the rising wait
		chk(n + 1, CAP_CYC);
		repeat (3) @(posedge clk);
		rdchk(`WPD_A_ADC, parasitic);
		// manual compensation code
		code = 5'($random(seed));
		wr(`WPD_A_CAPCTL, {code, 3'h0});
		// register lands at the write edge, the pin one edge later
		repeat (2) @(negedge clk);
		chk(cal_code, code);
		// automatic search, expect largest code still reading at or above target
		parasitic = 8'h80 | 8'($random(seed));
		code = (parasitic - 8'h80) / 4 > 31 ? 5'h1F : 5'((parasitic - 8'h80) / 4);
		wr(`WPD_A_CMD, `WPD_CMD_CALIB);
		repeat (5 * (CAP_CYC + 10) + 40) @(posedge clk);
		rdchk(`WPD_A_CAPDISP, {code, 3'h2});
		// wake mode: amp with host reference, phase auto-averaged
		thr = 4'h1 + 4'($random(seed) & 7);
		ref_v = 8'h20 + 8'($random(seed) & 8'h7F);
		wgt = 2'($random(seed));
		c1 = 8'h20 + 8'($random(seed) & 8'h7F);
		c2 = c1 + 8'($random(seed) & 15) - 8'h07;
		wr(`WPD_A_WUT, 8'h03);
		wr(`WPD_A_MBASE, {thr, 4'h0});
		wr(`WPD_A_MBASE + 8'h01, ref_v);
		wr(`WPD_A_MBASE + 8'h04, {4'hF, 1'b1, wgt, 1'b1});
		// a second bit beside wake keeps the mode off
		wr(`WPD_A_OPC, 8'h05);
		wait_for(0, 1'b1, PER_CYC + 200, 0, n);
		chk(n, -1);
		amp_val = ref_v - 8'(thr);
		phs_val = c1;
		wr(`WPD_A_OPC, `WPD_OPC_WU);
		wait_for(0, 1'b1, PER_CYC + 100, 1, n);
		chk(n >= PER_CYC - 8 && n <= PER_CYC + 2 * DIV + 8, 1'b1);
		chk(meas_sel, 2'h0);
		wait_for(0, 1'b0, FIELD_CYC + 50, 1, n);
		chk(n + 1, FIELD_CYC);
		wait_for(0, 1'b1, 50, 1, n);
		chk(meas_sel, 2'h1);
		wait_for(0, 1'b0, FIELD_CYC + 50, 1, n);
		repeat (10) @(posedge clk);
		// equal to threshold is no change
		rd(`WPD_A_CAUSE, v);
		chk(v[0], 1'b0);
		chk(exc_en, 1'b0);
		amp_val = ref_v + 8'(thr) + 8'h01;
		phs_val = c2;
		wait_for(0, 1'b1, PER_CYC + 100, 1, n);
		wait_for(0, 1'b0, FIELD_CYC + 50, 1, n);
		wait_for(0, 1'b1, 50, 1, n);
		wait_for(0, 1'b0, FIELD_CYC + 50, 1, n);
		repeat (10) @(posedge clk);
		chk(irq_cnt > 0, 1'b1);
		rd(`WPD_A_CAUSE, v);
		chk(v[0], 1'b1);
		rdchk(`WPD_A_CAUSE, 8'h00);
		rdchk(`WPD_A_MBASE + 8'h03, amp_val);
		rdchk(`WPD_A_MBASE + 8'h06, exp_avg(c1, c2, wgt));
		rdchk(`WPD_A_MBASE + 8'h07, c2);
		// leaving the mode stops the schedule
		wr(`WPD_A_OPC, `WPD_OPC_RST);
		wait_for(0, 1'b1, PER_CYC + 200, 0, n);
		chk(n, -1);
		results();
	end
endmodule
